// ---- include/cstat_pkg.sv ----
package cstat_pkg;
    // ****************************************************
    // register map and field layout
    // ****************************************************
    localparam logic [8:0] CSTAT_STATUS_OFFS = 9'h003;  // status offset in each bank
    localparam logic [6:0] CSTAT_BANK_MASK = 7'h7f;     // offset within a bank
    localparam int CSTAT_BIT_IND_BANK = 7;   // indirect bank select
    localparam int CSTAT_BIT_RPH = 6;   // direct bank select high
    localparam int CSTAT_BIT_RPL = 5;   // direct bank select low
    localparam int CSTAT_BIT_TIMEOUT = 4;    // watchdog time-out flag
    localparam int CSTAT_BIT_PWR_DOWN = 3;   // power-down flag
    localparam int CSTAT_BIT_Z = 2;     // zero flag
    localparam int CSTAT_BIT_DIGIT_C = 1;    // digit carry flag
    localparam int CSTAT_BIT_C = 0;     // carry flag
    localparam int CSTAT_NIB = 4;       // digit width
    // power-up value of the whole register (unknown flags taken as zero)
    localparam logic [7:0] CSTAT_RESET_VAL = 8'h18;
    // ****************************************************
    // alu operations that the flag unit understands
    // ****************************************************
    typedef enum logic [2:0] {
        CSTAT_OP_NONE,   // no flag effect
        CSTAT_OP_ADD,    // add, updates zero, digit carry and carry
        CSTAT_OP_SUB,    // subtract, updates zero, digit carry and carry
        CSTAT_OP_LOGIC,  // logic or inc/dec, updates z only
        CSTAT_OP_CLR,    // clear-file, result zero, updates z
        CSTAT_OP_RRC,    // rotate right through carry
        CSTAT_OP_RLC     // rotate left through carry
    } cstat_op_e;
endpackage

// ---- hw/cstat_flag_unit.sv ----
`timescale 1ns/1ps
// computes flag results of one alu operation, combinational
module cstat_flag_unit
    import cstat_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // operation and operands
    input wire cstat_op_e op,
    input wire logic [WIDTH-1:0] opa,
    input wire logic [WIDTH-1:0] opb,
    input wire logic carry_in,
    // results
    output logic [WIDTH-1:0] result,
    output logic z_upd,
    output logic z_val,
    output logic dig_upd,
    output logic dig_val,
    output logic c_upd,
    output logic c_val
);
    // ****************************************************
    // adder shared by add and subtract
    // ****************************************************
    logic [WIDTH-1:0] addend;   // second operand or its complement
    logic cin;                  // carry into bit 0
    logic [WIDTH:0] sum;        // full sum with carry out
    logic [CSTAT_NIB:0] nsum;   // low digit sum with digit carry

    // subtraction is opa + ~opb + 1, so carries read as inverted borrows
    always_comb begin
        addend = (op == CSTAT_OP_SUB) ? ~opb : opb;
        cin = (op == CSTAT_OP_SUB);
        sum = {1'b0, opa} + {1'b0, addend} + {{WIDTH{1'b0}}, cin};
        nsum = {1'b0, opa[CSTAT_NIB-1:0]} + {1'b0, addend[CSTAT_NIB-1:0]}
            + {{CSTAT_NIB{1'b0}}, cin};
    end

    // ****************************************************
    // result and flag selection
    // ****************************************************
    always_comb begin
        result = opa;
        z_upd = 1'b0;
        dig_upd = 1'b0;
        c_upd = 1'b0;
        dig_val = nsum[CSTAT_NIB];
        c_val = sum[WIDTH];
        case (op)
            CSTAT_OP_ADD, CSTAT_OP_SUB: begin
                result = sum[WIDTH-1:0];
                z_upd = 1'b1;
                dig_upd = 1'b1;
                c_upd = 1'b1;
            end
            CSTAT_OP_LOGIC: begin
                z_upd = 1'b1;
            end
            CSTAT_OP_CLR: begin
                result = '0;
                z_upd = 1'b1;
            end
            CSTAT_OP_RRC: begin
                // low bit leaves through carry
                result = {carry_in, opa[WIDTH-1:1]};
                c_upd = 1'b1;
                c_val = opa[0];
            end
            CSTAT_OP_RLC: begin
                // high bit leaves through carry
                result = {opa[WIDTH-2:0], carry_in};
                c_upd = 1'b1;
                c_val = opa[WIDTH-1];
            end
            default: begin
                result = opa;
            end
        endcase
        z_val = (result == '0);
    end
endmodule

// ---- hw/cstat_bank_decode.sv ----
`timescale 1ns/1ps
// turns the bank select bits into full data memory addresses
module cstat_bank_decode
    import cstat_pkg::*;
(
    // bank selects and low address parts
    input wire logic [1:0] direct_bank,
    input wire logic indirect_bank,
    input wire logic [6:0] direct_low,
    input wire logic [7:0] pointer,
    // full nine-bit addresses
    output logic [8:0] direct_addr,
    output logic [8:0] indirect_addr
);
    // 00 -> 00h-7fh, 01 -> 80h-ffh, 10 -> 100h-17fh, 11 -> 180h-1ffh
    assign direct_addr = {direct_bank, direct_low};
    // set selects banks 2-3, clear selects banks 0-1
    assign indirect_addr = {indirect_bank, pointer};
endmodule

// ---- hw/cstat_status_reg.sv ----
`timescale 1ns/1ps
// core status register: alu flags, reset cause and bank selects
module cstat_status_reg
    import cstat_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // file register write port from the instruction datapath
    input wire logic wr_en,
    input wire logic [8:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // alu operation of the executing instruction
    input wire cstat_op_e alu_op,
    input wire logic [WIDTH-1:0] alu_a,
    input wire logic [WIDTH-1:0] alu_b,
    input wire logic alu_dest_status,
    // reset-cause events, one-cycle pulses
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    // addressing inputs
    input wire logic [6:0] direct_low,
    input wire logic [7:0] pointer,
    // outputs
    output logic [WIDTH-1:0] core_status_flags,
    output logic [WIDTH-1:0] alu_result,
    output logic [8:0] direct_addr,
    output logic [8:0] indirect_addr
);
    // ****************************************************
    // state
    // ****************************************************
    logic [WIDTH-1:0] stat_q;       // the register itself
    logic [WIDTH-1:0] stat_d;       // next value
    logic [WIDTH-1:0] res_q;        // registered alu result
    logic [8:0] daddr_q;            // registered direct address
    logic [8:0] iaddr_q;            // registered indirect address
    logic [WIDTH-1:0] res;          // alu result
    logic z_upd, z_val, dig_upd, dig_val, c_upd, c_val;
    logic [8:0] daddr_c;            // decoded direct address
    logic [8:0] iaddr_c;            // decoded indirect address
    logic hit;                      // write targets the status register

    // ****************************************************
    // flag computation
    // ****************************************************
    cstat_flag_unit #(.WIDTH(WIDTH)) u_flags (
        .op(alu_op),
        .opa(alu_a),
        .opb(alu_b),
        .carry_in(stat_q[CSTAT_BIT_C]),
        .result(res),
        .z_upd(z_upd),
        .z_val(z_val),
        .dig_upd(dig_upd),
        .dig_val(dig_val),
        .c_upd(c_upd),
        .c_val(c_val)
    );

    // ****************************************************
    // bank address decode
    // ****************************************************
    cstat_bank_decode u_bank (
        .direct_bank(stat_q[CSTAT_BIT_RPH:CSTAT_BIT_RPL]),
        .indirect_bank(stat_q[CSTAT_BIT_IND_BANK]),
        .direct_low(direct_low),
        .pointer(pointer),
        .direct_addr(daddr_c),
        .indirect_addr(iaddr_c)
    );

    // the register appears at the same offset in every bank
    assign hit = wr_en && ((wr_addr & {2'b00, CSTAT_BANK_MASK}) == CSTAT_STATUS_OFFS);

    // ****************************************************
    // next value of the status register
    // ****************************************************
    // order matters: instruction write first, then alu flags override the
    // masked bits, then reset-cause events, which no write may touch
    always_comb begin
        stat_d = stat_q;
        if (hit) begin
            // writable bits take the data like any file register
            stat_d[CSTAT_BIT_IND_BANK] = wr_data[CSTAT_BIT_IND_BANK];
            stat_d[CSTAT_BIT_RPH] = wr_data[CSTAT_BIT_RPH];
            stat_d[CSTAT_BIT_RPL] = wr_data[CSTAT_BIT_RPL];
            // time-out and power-down ignore the data
            stat_d[CSTAT_BIT_TIMEOUT] = stat_q[CSTAT_BIT_TIMEOUT];
            stat_d[CSTAT_BIT_PWR_DOWN] = stat_q[CSTAT_BIT_PWR_DOWN];
            // an op touching any alu flag blocks the write of all three, so a
            // clear-file or rotate leaves the flags it does not set unchanged
            if (!(z_upd || dig_upd || c_upd)) begin
                stat_d[CSTAT_BIT_Z] = wr_data[CSTAT_BIT_Z];
                stat_d[CSTAT_BIT_DIGIT_C] = wr_data[CSTAT_BIT_DIGIT_C];
                stat_d[CSTAT_BIT_C] = wr_data[CSTAT_BIT_C];
            end
        end
        // alu flags win over a write of the same bits
        if (z_upd) begin
            stat_d[CSTAT_BIT_Z] = z_val;
        end
        if (dig_upd) begin
            stat_d[CSTAT_BIT_DIGIT_C] = dig_val;
        end
        if (c_upd) begin
            stat_d[CSTAT_BIT_C] = c_val;
        end
        // a clear-file of the register itself zeroes the bank bits
        if (alu_op == CSTAT_OP_CLR && alu_dest_status) begin
            stat_d[CSTAT_BIT_IND_BANK] = 1'b0;
            stat_d[CSTAT_BIT_RPH] = 1'b0;
            stat_d[CSTAT_BIT_RPL] = 1'b0;
        end
        // reset-cause events
        if (clear_watchdog_instr) begin
            stat_d[CSTAT_BIT_TIMEOUT] = 1'b1;
            stat_d[CSTAT_BIT_PWR_DOWN] = 1'b1;
        end
        if (sleep_instr) begin
            stat_d[CSTAT_BIT_TIMEOUT] = 1'b1;
            stat_d[CSTAT_BIT_PWR_DOWN] = 1'b0;
        end
        // a time-out is a hardware event and wins over the instructions
        if (watchdog_timeout) begin
            stat_d[CSTAT_BIT_TIMEOUT] = 1'b0;
        end
    end

    // ****************************************************
    // status register
    // ****************************************************
    // power-up leaves time-out and power-down set
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stat_q <= CSTAT_RESET_VAL;
        end else begin
            stat_q <= stat_d;
        end
    end

    // ****************************************************
    // registered result and addresses
    // ****************************************************
    // addresses lag the bank bits by one cycle so outputs come from flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            res_q <= '0;
            daddr_q <= '0;
            iaddr_q <= '0;
        end else begin
            res_q <= res;
            daddr_q <= daddr_c;
            iaddr_q <= iaddr_c;
        end
    end

    assign core_status_flags = stat_q;
    assign alu_result = res_q;
    assign direct_addr = daddr_q;
    assign indirect_addr = iaddr_q;
endmodule

// ---- test/cstat_status_reg_monitor.sv ----
`timescale 1ns/1ps
// ****************************************************
// port-level checks of the status register
// ****************************************************
module cstat_status_reg_monitor
    import cstat_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // stimulus seen by the register
    input wire logic wr_en,
    input wire logic [8:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire cstat_op_e alu_op,
    input wire logic [WIDTH-1:0] alu_a,
    input wire logic [WIDTH-1:0] alu_b,
    input wire logic alu_dest_status,
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    // register outputs
    input wire logic [WIDTH-1:0] core_status_flags,
    input wire logic [WIDTH-1:0] alu_result
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // reference sums, one bit wider so the carry-out stays visible
    logic [WIDTH:0] sum_w;
    logic [WIDTH:0] dif_w;
    logic [CSTAT_NIB:0] nib_w;
    assign sum_w = {1'b0, alu_a} + {1'b0, alu_b};
    assign dif_w = {1'b0, alu_a} + {1'b0, ~alu_b} + {{WIDTH{1'b0}}, 1'b1};
    assign nib_w = {1'b0, alu_a[CSTAT_NIB-1:0]} + {1'b0, alu_b[CSTAT_NIB-1:0]};
    a_write_bits: assert property (wr_en && wr_addr[6:0] == 7'h03
        && alu_op == CSTAT_OP_NONE |=> core_status_flags[7:5] == $past(wr_data[7:5])
        && core_status_flags[2:0] == $past(wr_data[2:0])) else $error("status write lost");
    a_cause_hold: assert property (wr_en && !clear_watchdog_instr && !sleep_instr
        && !watchdog_timeout |=> $stable(core_status_flags[4:3])) else $error("cause bits written");
    a_sleep_flags: assert property (sleep_instr && !watchdog_timeout
        |=> core_status_flags[4:3] == 2'b10) else $error("sleep flags wrong");
    a_wdt_clears: assert property (watchdog_timeout
        |=> !core_status_flags[CSTAT_BIT_TIMEOUT]) else $error("time-out flag not cleared");
    a_add_flags: assert property (alu_op == CSTAT_OP_ADD |=> core_status_flags[1:0]
        == {$past(nib_w[CSTAT_NIB]), $past(sum_w[WIDTH])}) else $error("add carries wrong");
    a_sub_carry: assert property (alu_op == CSTAT_OP_SUB |=> core_status_flags[CSTAT_BIT_C]
        == $past(dif_w[WIDTH])) else $error("borrow polarity wrong");
    a_zero_result: assert property (alu_op inside {CSTAT_OP_ADD, CSTAT_OP_SUB}
        |=> core_status_flags[CSTAT_BIT_Z] == ($past(alu_op) == CSTAT_OP_ADD ?
        ($past(sum_w[WIDTH-1:0]) == '0) : ($past(dif_w[WIDTH-1:0]) == '0)))
        else $error("zero flag wrong");
    a_flag_write_block: assert property (wr_en && wr_addr[6:0] == 7'h03
        && alu_op == CSTAT_OP_CLR |=> core_status_flags[1:0] == $past(core_status_flags[1:0]))
        else $error("blocked flags written");
    a_rotate_carry: assert property (alu_op inside {CSTAT_OP_RRC, CSTAT_OP_RLC}
        |=> core_status_flags[CSTAT_BIT_C] == ($past(alu_op) == CSTAT_OP_RLC ?
        $past(alu_a[WIDTH-1]) : $past(alu_a[0]))) else $error("rotate carry wrong");
    a_clear_file: assert property (alu_op == CSTAT_OP_CLR && alu_dest_status
        |=> core_status_flags[7:5] == 3'b000 && core_status_flags[CSTAT_BIT_Z])
        else $error("clear-file result wrong");
endmodule
bind cstat_status_reg cstat_status_reg_monitor #(.WIDTH(WIDTH)) u_cstat_status_reg_monitor (
    .clk(clk), .reset(reset), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_dest_status(alu_dest_status),
    .clear_watchdog_instr(clear_watchdog_instr), .sleep_instr(sleep_instr),
    .watchdog_timeout(watchdog_timeout), .core_status_flags(core_status_flags),
    .alu_result(alu_result));

// ---- test/cstat_status_reg_tb_top.sv ----
`timescale 1ns/1ps
// ****************************************************
// directed bench of the status register
// ****************************************************
module cstat_status_reg_tb_top;
    import cstat_pkg::*;
    logic clk;
    logic reset = 1'b1;
    logic wr_en = 1'b0;
    logic [8:0] wr_addr = 9'h000;
    logic [7:0] wr_data = 8'h00;
    cstat_op_e alu_op = CSTAT_OP_NONE;
    logic [7:0] alu_a = 8'h00;
    logic [7:0] alu_b = 8'h00;
    // events packed as {dest, clear-watchdog, sleep, timeout}
    logic dest = 1'b0;
    logic cw = 1'b0;
    logic sl = 1'b0;
    logic wd = 1'b0;
    // fixed address parts so every bank code gives a distinct address
    logic [6:0] direct_low = 7'h7f;
    logic [7:0] pointer = 8'haa;
    logic [7:0] flags;
    logic [7:0] res;
    logic [8:0] daddr;
    logic [8:0] iaddr;
    int num_errors = 0;
    int n_tests = 0;
    cstat_status_reg u_cstat_status_reg (.clk(clk), .reset(reset), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
        .alu_dest_status(dest), .clear_watchdog_instr(cw), .sleep_instr(sl),
        .watchdog_timeout(wd), .direct_low(direct_low), .pointer(pointer),
        .core_status_flags(flags), .alu_result(res), .direct_addr(daddr), .indirect_addr(iaddr));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one instruction cycle, then the register value one cycle later
    task automatic step(input logic w, input logic [8:0] ad, input logic [7:0] d,
            input cstat_op_e op, input logic [7:0] a, input logic [7:0] b,
            input logic [3:0] ev, input logic [7:0] exp);
        @(posedge clk);
        wr_en <= w;
        wr_addr <= ad;
        wr_data <= d;
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        {dest, cw, sl, wd} <= ev;
        @(posedge clk);
        wr_en <= 1'b0;
        alu_op <= CSTAT_OP_NONE;
        {dest, cw, sl, wd} <= 4'h0;
        #1;
        chk(flags, exp);
    endtask
    task automatic t_alu();
        step(1'b1, 9'h003, 8'hff, CSTAT_OP_NONE, 8'h00, 8'h00, 4'h0, 8'hff);
        step(1'b1, 9'h083, 8'h00, CSTAT_OP_NONE, 8'h00, 8'h00, 4'h0, 8'h18);
        step(1'b1, 9'h103, 8'hff, CSTAT_OP_ADD, 8'h01, 8'h01, 4'h0, 8'hf8);
        chk(res, 9'h002);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_ADD, 8'h0f, 8'h01, 4'h0, 8'hfa);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_ADD, 8'hff, 8'h01, 4'h0, 8'hff);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_SUB, 8'h05, 8'h05, 4'h0, 8'hff);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_SUB, 8'h03, 8'h05, 4'h0, 8'hf8);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_SUB, 8'h10, 8'h01, 4'h0, 8'hf9);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_RLC, 8'h7f, 8'h00, 4'h0, 8'hf8);
        chk(res, 9'h0ff);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_RRC, 8'h01, 8'h00, 4'h0, 8'hf9);
        chk(res, 9'h000);
        $display("alu flag test done");
    endtask
    // clear-file first, so the events start from a known low bank field
    task automatic t_events();
        step(1'b1, 9'h183, 8'h00, CSTAT_OP_CLR, 8'h00, 8'h00, 4'h8, 8'h1d);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_NONE, 8'h00, 8'h00, 4'h2, 8'h15);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_NONE, 8'h00, 8'h00, 4'h1, 8'h05);
        step(1'b1, 9'h003, 8'hff, CSTAT_OP_NONE, 8'h00, 8'h00, 4'h0, 8'he7);
        step(1'b0, 9'h000, 8'h00, CSTAT_OP_NONE, 8'h00, 8'h00, 4'h4, 8'hff);
        $display("event test done");
    endtask
    task automatic t_bank();
        for (int i = 0; i < 4; i++) begin
            step(1'b1, {i[1:0], 7'h03}, {i[0], i[1:0], 5'h00}, CSTAT_OP_NONE, 8'h00, 8'h00,
                4'h0, {i[0], i[1:0], 5'h18});
            // addresses follow the bank bits one cycle later
            @(posedge clk);
            #1;
            chk(daddr, {i[1:0], 7'h7f});
            chk(iaddr, {i[0], 8'haa});
        end
        $display("bank test done");
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(flags, 8'h18);
        t_alu();
        t_events();
        t_bank();
        summarize();
    end
    // the tests need about 1.2 us; the 30 us limit, some 25 times that, means a hang
    initial begin
        #30000;
        num_errors++;
        summarize();
    end
endmodule
